// [rtl/page_register_and_logic_cells.sv]
// Purpose: Memory page register, decode array and general logic array
// Assumes: Fuse map is static; pins arrive asynchronously
// Notes: Array outputs are registered, one cycle behind inputs
`timescale 1ns/1ps
`include "page_logic_cfg.svh"

// Function
// (RL1) Eight-bit page register, written and read
// (RL2) Page register answers at offset e0
// (RL3) Page bits feed the decode array
// (RL4) Page bits also feed the general array
// (RL5) Slow mode: idle arrays enter standby
// (RL6) Five bits block core strobes; here bits 3:0 block the four core strobes and bit 4 blocks power_down_input
// (RL7) Eight primary selects, three terms each
// (RL8) Four secondary selects, three terms each
// (RL9) One SRAM select, two terms
// (RL10) Register space and two peripheral selects
// (RL11) Common input set for both arrays
// (RL12) 20 input, 16 output cells, 137 terms
// (RL13) External chip selects use dedicated terms
// (RL14) Core loads and reads back cells; here a load in standby is lost unless arr_in changes or fast_decode is set
// (RL15) Output cells form two groups of eight
// (RL16) XOR stage sets output polarity
// (RL17) Registered or combinational select, fed back
// (RL18) Flip-flop type D, T, JK or SR
// (RL19) Clock from term or pin rise
// (RL20) Term-driven preset and two-term clear
// (RL21) Cell n maps to data bit n
// (RL22) Native and borrowed term budgets per cell
// (RL23) Page register clears at reset
module page_register_and_logic_cells (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire page_logic_pkg::fuse_map_s fuse,
	input wire page_logic_pkg::reg_req_s req,
	input wire page_logic_pkg::mcu_sig_s mcu,
	input wire logic fast_decode,
	input wire logic [4:0] strobe_block,
	input wire logic power_down_input,
	input wire logic flash_ready,
	input wire logic [`IN_CELLS-1:0] port_in,
	input wire logic port_d_in,
	input wire logic cell_clock_pin,
	output logic [7:0] rdata,
	output logic [7:0] page_bits,
	output page_logic_pkg::selects_s selects,
	output logic [7:0] output_cells_group_a,
	output logic [7:0] output_cells_group_b,
	output logic [1:0] external_chip_selects,
	output logic standby
);
	import page_logic_pkg::*;

	// ============================================================
	// State
	typedef struct packed {
		logic [21:0] sync1;
		logic [21:0] sync2;
		logic [7:0] page;
		logic [15:0] cell_q;
		logic [15:0] cell_out;
		logic [15:0] clk_term_prev;
		logic pin_prev;
		selects_s sel;
		logic [1:0] ecs;
		logic [7:0] rdata;
		logic [`ARR_IN-1:0] prev_in;
		logic [3:0] idle_cnt;
		arr_state_e pstate;
	} state_s;

	state_s st;
	state_s next_st;

	// ============================================================
	// Array inputs
	logic [`ARR_IN-1:0] arr_in;
	logic [3:0] strobes;
	logic [`IN_CELLS-1:0] in_cells;
	logic pin_clk;
	logic [`DEC_TERMS-1:0] dt;
	logic [`GEN_TERMS-1:0] gt;
	logic arr_changed;
	logic load_a;
	logic load_b;

	assign in_cells = st.sync2[`IN_CELLS-1:0];
	assign pin_clk = st.sync2[21];
	// Blocked strobes are forced inactive [RL6]
	assign strobes = {mcu.latch, mcu.write, mcu.read, mcu.fetch} & ~strobe_block[3:0];
	// Same input set for both arrays [RL11] [RL3] [RL4]
	assign arr_in = {flash_ready, st.cell_out, st.page, st.sync2[21:20], in_cells,
		power_down_input & ~strobe_block[4], ~resetn, strobes, mcu.addr};
	assign arr_changed = arr_in != st.prev_in;
	assign load_a = req.window && req.wr && req.offset == `CELLS_A_OFS;
	assign load_b = req.window && req.wr && req.offset == `CELLS_B_OFS;

	// ============================================================
	// Product terms
	genvar k;
	generate
		for (k = 0; k < `GEN_TERMS; k++) begin : g_terms
			assign gt[k] = &(arr_in | ~fuse.gen_true[k]) & &(~arr_in | ~fuse.gen_comp[k]);
			if (k < `DEC_TERMS) begin : g_dec
				assign dt[k] = &(arr_in | ~fuse.dec_true[k]) & &(~arr_in | ~fuse.dec_comp[k]);
			end
		end
	endgenerate

	// ============================================================
	// Output cell terms
	logic [15:0] cell_xor;
	logic [15:0] cell_set;
	logic [15:0] cell_rst;
	logic [15:0] cell_clk_term;
	logic [15:0] cell_preset;
	logic [15:0] cell_clear;

	genvar c;
	generate
		for (c = 0; c < `OUT_CELLS; c++) begin : g_cells
			localparam int NAT = (c < 8) ? 3 : 4;
			localparam int BASE = (c < 8) ? 3 * c : `GT_NAT_B + 4 * (c - 8);
			localparam int BUDGET = (c < 8) ? 6 : ((c < 12) ? 5 : 6);
			localparam logic [5:0] BMASK = (BUDGET == 6) ? 6'h3f : 6'h1f;
			logic [3:0] nat;
			logic [5:0] borrowed;
			assign nat = (NAT == 3) ? {1'b0, gt[BASE+2:BASE]} : gt[BASE+3:BASE]; // [RL22]
			assign borrowed = gt[`GT_POOL + (c % 10) +: 6] & fuse.cell_cfg[c].borrow_en
				& BMASK; // [RL22]
			assign cell_xor[c] = (|nat | |borrowed) ^ fuse.cell_cfg[c].polarity; // [RL16]
			assign cell_set[c] = nat[0];
			assign cell_rst[c] = |nat[3:1] | |borrowed;
			assign cell_clk_term[c] = gt[`GT_CLK + c];
			assign cell_preset[c] = gt[`GT_PRESET + c]; // [RL20]
			assign cell_clear[c] = gt[`GT_CLEAR + 2 * c] | gt[`GT_CLEAR + 2 * c + 1]; // [RL20]
		end
	endgenerate

	// ============================================================
	// Next state
	always_comb begin
		logic edge_hit;
		logic q;
		edge_hit = 1'b0;
		q = 1'b0;
		next_st = st;
		next_st.sync1 = {cell_clock_pin, port_d_in, port_in};
		next_st.sync2 = st.sync1;
		next_st.pin_prev = pin_clk;
		next_st.clk_term_prev = cell_clk_term;
		next_st.prev_in = arr_in;

		if (req.window && req.wr && req.offset == `PAGE_OFS) begin
			next_st.page = req.wdata; // [RL1] [RL2]
		end

		if (req.window && req.rd) begin
			case (req.offset)
				`PAGE_OFS: next_st.rdata = st.page; // [RL1] [RL2]
				`INCELL_A_OFS: next_st.rdata = in_cells[7:0]; // [RL14]
				`INCELL_B_OFS: next_st.rdata = in_cells[15:8];
				`INCELL_C_OFS: next_st.rdata = {4'h0, in_cells[19:16]};
				`CELLS_A_OFS: next_st.rdata = st.cell_q[7:0]; // [RL21]
				`CELLS_B_OFS: next_st.rdata = st.cell_q[15:8];
				default: next_st.rdata = 8'h00;
			endcase
		end

		// Standby after quiet inputs, wake on any change [RL5]
		if (fast_decode || arr_changed) begin
			next_st.idle_cnt = 4'h0;
			next_st.pstate = ARR_ACTIVE;
		end else if (st.pstate == ARR_ACTIVE) begin
			if (st.idle_cnt >= 4'(`STANDBY_CYC - 1)) begin
				next_st.pstate = ARR_STANDBY;
			end else begin
				next_st.idle_cnt = st.idle_cnt + 4'h1;
			end
		end

		// Frozen arrays in standby; inputs are unchanged there anyway
		if (st.pstate == ARR_ACTIVE || arr_changed || fast_decode) begin
			for (int i = 0; i < 8; i++) begin
				next_st.sel.primary[i] = |dt[`DT_PRIMARY + 3 * i +: 3]; // [RL7]
			end
			for (int i = 0; i < 4; i++) begin
				next_st.sel.secondary[i] = |dt[`DT_SECONDARY + 3 * i +: 3]; // [RL8]
			end
			next_st.sel.sram = |dt[`DT_SRAM +: 2]; // [RL9]
			next_st.sel.regspace = dt[`DT_REGSPACE]; // [RL10]
			next_st.sel.periph = dt[`DT_PERIPH +: 2]; // [RL10]
			next_st.ecs = gt[`GT_ECS +: 2]; // [RL13]

			for (int i = 0; i < `OUT_CELLS; i++) begin
				q = st.cell_q[i];
				// Pin edge or rising product term [RL19]
				edge_hit = fuse.cell_cfg[i].clk_pin ? (pin_clk && !st.pin_prev)
					: (cell_clk_term[i] && !st.clk_term_prev[i]);
				if ((i < 8 && load_a) || (i >= 8 && load_b)) begin
					q = req.wdata[i % 8]; // [RL14] [RL21]
				end else if (cell_clear[i]) begin
					q = 1'b0; // [RL20]
				end else if (cell_preset[i]) begin
					q = 1'b1; // [RL20]
				end else if (edge_hit) begin
					case (fuse.cell_cfg[i].ff_type) // [RL18]
						FF_D: q = cell_xor[i];
						FF_T: q = st.cell_q[i] ^ cell_xor[i];
						FF_JK: begin
							if (cell_set[i] && cell_rst[i]) begin
								q = ~st.cell_q[i];
							end else if (cell_set[i]) begin
								q = 1'b1;
							end else if (cell_rst[i]) begin
								q = 1'b0;
							end
						end
						FF_SR: begin
							if (cell_set[i]) begin
								q = 1'b1;
							end else if (cell_rst[i]) begin
								q = 1'b0;
							end
						end
						default: q = st.cell_q[i];
					endcase
				end
				next_st.cell_q[i] = q;
				// Output mux, fed back through arr_in [RL17]
				next_st.cell_out[i] = fuse.cell_cfg[i].reg_sel ? q : cell_xor[i];
			end
		end
	end

	// ============================================================
	// Registers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st <= '0;
			st.page <= `PAGE_RESET; // [RL23]
			st.pstate <= ARR_ACTIVE;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Group A cells drive ports A/B, group B ports B/C [RL15] [RL12]
	assign rdata = st.rdata;
	assign page_bits = st.page;
	assign selects = st.sel;
	assign output_cells_group_a = st.cell_out[7:0];
	assign output_cells_group_b = st.cell_out[15:8];
	assign external_chip_selects = st.ecs;
	assign standby = st.pstate;

	// ============================================================
	// Assertions
	page_write_a: assert property (@(posedge clk) disable iff (!resetn) // [RL1]
		ce && req.window && req.wr && req.offset == `PAGE_OFS |=> page_bits == $past(req.wdata))
		else $error("page register write lost");
	page_read_a: assert property (@(posedge clk) disable iff (!resetn) // [RL2]
		ce && req.window && req.rd && req.offset == `PAGE_OFS |=> rdata == $past(st.page))
		else $error("page register read wrong");
	page_reset_a: assert property (@(posedge clk) // [RL23]
		!resetn |=> page_bits == 8'h00)
		else $error("page register not cleared by reset");
	strobe_block_a: assert property (@(posedge clk) disable iff (!resetn) // [RL6]
		strobe_block[2] |-> !arr_in[`IN_STROBE + 2])
		else $error("blocked write strobe reached array");
	standby_entry_a: assert property (@(posedge clk) disable iff (!resetn) // [RL5]
		(ce && !fast_decode && !arr_changed)[*3] |=> standby)
		else $error("arrays failed to enter standby");
	standby_wake_a: assert property (@(posedge clk) disable iff (!resetn) // [RL5]
		ce && standby && arr_changed |=> !standby)
		else $error("arrays did not wake on input change");
	sram_select_a: assert property (@(posedge clk) disable iff (!resetn) // [RL9]
		ce && (st.pstate == ARR_ACTIVE) |=> selects.sram == $past(|dt[`DT_SRAM +: 2]))
		else $error("sram select does not follow its terms");
	cell_load_a: assert property (@(posedge clk) disable iff (!resetn) // [RL14]
		ce && load_a |=> st.cell_q[7:0] == $past(req.wdata))
		else $error("group a load lost");
	cell_clear_a: assert property (@(posedge clk) disable iff (!resetn) // [RL20]
		ce && cell_clear[8] && !load_b && (st.pstate == ARR_ACTIVE) |=> !st.cell_q[8])
		else $error("clear term did not clear cell");
	chip_select_a: assert property (@(posedge clk) disable iff (!resetn) // [RL13]
		ce && fast_decode |=> external_chip_selects == $past(gt[`GT_ECS +: 2]))
		else $error("chip selects do not follow dedicated terms");
	cell_load_b_a: assert property (@(posedge clk) disable iff (!resetn) // [RL14] [RL21]
		ce && load_b |=> st.cell_q[15:8] == $past(req.wdata))
		else $error("group b load lost");
	primary_sel_a: assert property (@(posedge clk) disable iff (!resetn) // [RL7]
		ce && (st.pstate == ARR_ACTIVE) |=> selects.primary[0] == $past(|dt[`DT_PRIMARY +: 3]))
		else $error("primary select does not follow its terms");
	secondary_sel_a: assert property (@(posedge clk) disable iff (!resetn) // [RL8]
		ce && (st.pstate == ARR_ACTIVE) |=> selects.secondary[0] == $past(|dt[`DT_SECONDARY +: 3]))
		else $error("secondary select does not follow its terms");
	regspace_sel_a: assert property (@(posedge clk) disable iff (!resetn) // [RL10]
		ce && (st.pstate == ARR_ACTIVE) |=> selects.regspace == $past(dt[`DT_REGSPACE]))
		else $error("register space select does not follow its term");
	periph_sel_a: assert property (@(posedge clk) disable iff (!resetn) // [RL10]
		ce && (st.pstate == ARR_ACTIVE) |=> selects.periph == $past(dt[`DT_PERIPH +: 2]))
		else $error("peripheral selects do not follow their terms");
	cell_preset_a: assert property (@(posedge clk) disable iff (!resetn) // [RL20]
		ce && cell_preset[10] && !cell_clear[10] && !load_b && (st.pstate == ARR_ACTIVE)
		|=> st.cell_q[10])
		else $error("preset term did not set cell");
	pin_sync_a: assert property (@(posedge clk) disable iff (!resetn) // [RL19]
		ce |=> st.sync2 == $past(st.sync1))
		else $error("pin synchroniser skipped a stage");
	rdata_hold_a: assert property (@(posedge clk) disable iff (!resetn) // [RL1]
		!(ce && req.window && req.rd) |=> $stable(rdata))
		else $error("read data changed without a read");
	ce_freeze_a: assert property (@(posedge clk) disable iff (!resetn) // [RL1]
		!ce |=> $stable(page_bits) && $stable(output_cells_group_a))
		else $error("state moved while clock enable low");

	page_write_c: cover property (@(posedge clk) disable iff (!resetn)
		ce && req.window && req.wr && req.offset == `PAGE_OFS);
	cell_load_c: cover property (@(posedge clk) disable iff (!resetn) ce && load_b);
	standby_c: cover property (@(posedge clk) disable iff (!resetn) !standby ##1 standby);
	pin_edge_c: cover property (@(posedge clk) disable iff (!resetn) pin_clk && !st.pin_prev);

	// ============================================================
	// Preset term reaching a group B cell
	preset_c: cover property (@(posedge clk) disable iff (!resetn) ce && cell_preset[10]);

endmodule

// [rtl/page_logic_cfg.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Register window offsets are the low eight address bits
// Notes: Definitions only
`ifndef PAGE_LOGIC_CFG_SVH
`define PAGE_LOGIC_CFG_SVH

// ============================================================
// Register offsets within the module register space
`define PAGE_OFS 8'he0
`define INCELL_A_OFS 8'h10
`define INCELL_B_OFS 8'h11
`define INCELL_C_OFS 8'h12
`define CELLS_A_OFS 8'h20
`define CELLS_B_OFS 8'h21
`define PAGE_RESET 8'h00

// ============================================================
// Array sizes
`define ARR_IN 69
`define DEC_TERMS 41
`define GEN_TERMS 137
`define IN_CELLS 20
`define OUT_CELLS 16

// ============================================================
// Decode array term positions
`define DT_PRIMARY 0
`define DT_SECONDARY 24
`define DT_SRAM 36
`define DT_REGSPACE 38
`define DT_PERIPH 39

// ============================================================
// General array term positions
`define GT_NAT_B 24
`define GT_CLK 56
`define GT_PRESET 72
`define GT_CLEAR 88
`define GT_ECS 120
`define GT_POOL 122

// ============================================================
// Array input vector positions
`define IN_STROBE 16
`define IN_RESET 20
`define IN_PDN 21
`define IN_CELLS_POS 22
`define IN_PORTD 42
`define IN_PAGE 44
`define IN_FB 52
`define IN_READY 68

// ============================================================
// Standby timing
`define STANDBY_NS 70
`define CLK_NS 50
`define STANDBY_CYC ((`STANDBY_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [rtl/page_logic_pkg.sv]
// Purpose: Types shared by the page register and logic cells
// Assumes: page_logic_cfg.svh supplies the sizes
// Notes: Types only
`include "page_logic_cfg.svh"

package page_logic_pkg;

	typedef enum logic [1:0] {
		FF_D = 2'b00,
		FF_T = 2'b01,
		FF_JK = 2'b10,
		FF_SR = 2'b11
	} ff_type_e;

	typedef enum logic {
		ARR_ACTIVE = 1'b0,
		ARR_STANDBY = 1'b1
	} arr_state_e;

	typedef struct packed {
		logic polarity;
		logic reg_sel;
		ff_type_e ff_type;
		logic clk_pin;
		logic [5:0] borrow_en;
	} cell_cfg_s;

	typedef struct packed {
		logic [`DEC_TERMS-1:0][`ARR_IN-1:0] dec_true;
		logic [`DEC_TERMS-1:0][`ARR_IN-1:0] dec_comp;
		logic [`GEN_TERMS-1:0][`ARR_IN-1:0] gen_true;
		logic [`GEN_TERMS-1:0][`ARR_IN-1:0] gen_comp;
		logic [`OUT_CELLS-1:0] cell_cfg_dummy;
		cell_cfg_s [`OUT_CELLS-1:0] cell_cfg;
	} fuse_map_s;

	typedef struct packed {
		logic window;
		logic wr;
		logic rd;
		logic [7:0] offset;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic fetch;
		logic read;
		logic write;
		logic latch;
		logic [15:0] addr;
	} mcu_sig_s;

	typedef struct packed {
		logic [7:0] primary;
		logic [3:0] secondary;
		logic sram;
		logic regspace;
		logic [1:0] periph;
	} selects_s;

endpackage

// [sim/core_model.sv]
// Purpose: Core side of the module register space and strobes
// Assumes: Requests start on a rising edge, one pulse each
// Notes: Read data sampled after the answering edge
`timescale 1ns/1ps
`include "page_logic_cfg.svh"

module core_model import page_logic_pkg::*; (
	input wire logic clk,
	input wire logic [7:0] rdata,
	output page_logic_pkg::reg_req_s req,
	output page_logic_pkg::mcu_sig_s mcu
);
	initial begin
		req = '0;
		mcu = '0;
	end

	// ============================================================
	// Register space cycles
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		@(posedge clk);
		req <= '{window: 1'b1, wr: 1'b1, rd: 1'b0, offset: ofs, wdata: d};
		@(posedge clk);
		req <= '0;
	endtask

	task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
		@(posedge clk);
		req <= '{window: 1'b1, wr: 1'b0, rd: 1'b1, offset: ofs, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		#1 d = rdata;
	endtask

	// ============================================================
	// Address and strobe levels
	task automatic bus(input mcu_sig_s v);
		@(posedge clk);
		mcu <= v;
	endtask
endmodule

// [sim/test_page_register_and_logic_cells.sv]
// Purpose: Self-checking bench for page register and logic cells
// Assumes: Group A is cell 0-7, group B cell 8-15
// Notes: Unused terms are forced false by opposing masks
`timescale 1ns/1ps
`include "page_logic_cfg.svh"

module test_page_register_and_logic_cells;
	import page_logic_pkg::*;
	logic clk, resetn, ce, fast_decode, cell_clock_pin;
	logic [4:0] strobe_block;
	logic [19:0] port_in;
	fuse_map_s fuse;
	reg_req_s req;
	mcu_sig_s mcu;
	logic [7:0] rdata, page_bits, ga, gb, d;
	selects_s selects;
	logic [1:0] ecs;
	logic standby;
	int n_fail, checks;

	core_model core_u (.clk(clk), .rdata(rdata), .req(req), .mcu(mcu));

	page_register_and_logic_cells dut_u (.clk(clk), .resetn(resetn), .ce(ce), .fuse(fuse),
		.req(req), .mcu(mcu), .fast_decode(fast_decode), .strobe_block(strobe_block),
		.power_down_input(1'b0), .flash_ready(1'b0), .port_in(port_in), .port_d_in(1'b0),
		.cell_clock_pin(cell_clock_pin), .rdata(rdata), .page_bits(page_bits),
		.selects(selects), .output_cells_group_a(ga), .output_cells_group_b(gb),
		.external_chip_selects(ecs), .standby(standby));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ============================================================
	// Helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One input drives one term; b < 0 makes it false
	task automatic term(input bit g, input int t, input int b);
		logic [`ARR_IN-1:0] m;
		m = (b < 0) ? (`ARR_IN'(1) << `IN_READY) : (`ARR_IN'(1) << b);
		@(posedge clk);
		if (g) begin
			fuse.gen_true[t] <= m;
			fuse.gen_comp[t] <= (b < 0) ? m : '0;
		end else begin
			fuse.dec_true[t] <= m;
			fuse.dec_comp[t] <= (b < 0) ? m : '0;
		end
	endtask

	task automatic end_sim;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ============================================================
	// Scenarios
	task automatic t_page;
		chk(page_bits, 8'h00);
		core_u.rd(8'he0, d);
		chk(d, 8'h00);
		core_u.wr(8'he0, 8'ha5);
		core_u.wr(8'he0, 8'h3c);
		core_u.rd(8'he0, d);
		chk(d, 8'h3c);
		chk(page_bits, 8'h3c);
		core_u.rd(8'h7f, d);
		chk(d, 8'h00);
	endtask

	task automatic t_decode;
		term(0, `DT_SRAM, `IN_PAGE);
		term(0, `DT_PRIMARY, 15);
		core_u.wr(8'he0, 8'h01);
		core_u.bus('{fetch: 1'b0, read: 1'b0, write: 1'b0, latch: 1'b0, addr: 16'h8000});
		settle(3);
		chk(8'(selects.sram), 8'h01);
		chk(selects.primary, 8'h01);
		core_u.wr(8'he0, 8'h00);
		settle(3);
		chk(8'(selects.sram), 8'h00);
	endtask

	task automatic t_block;
		term(0, `DT_SRAM + 1, `IN_STROBE + 1);
		core_u.bus('{fetch: 1'b0, read: 1'b1, write: 1'b0, latch: 1'b0, addr: 16'h0000});
		settle(3);
		chk(8'(selects.sram), 8'h01);
		@(posedge clk);
		strobe_block <= 5'h02;
		settle(3);
		chk(8'(selects.sram), 8'h00);
		@(posedge clk);
		strobe_block <= 5'h00;
	endtask

	task automatic t_cells;
		core_u.wr(8'h20, 8'ha5);
		core_u.wr(8'h21, 8'h5a);
		core_u.rd(8'h20, d);
		chk(d, 8'ha5);
		core_u.rd(8'h21, d);
		chk(d, 8'h5a);
		settle(1);
		chk(ga, 8'ha5);
		chk(gb, 8'h5a);
		term(1, `GT_CLEAR, `IN_PAGE + 1);
		core_u.wr(8'he0, 8'h02);
		settle(3);
		chk(ga, 8'ha4);
		term(1, `GT_CLEAR, -1);
	endtask

	task automatic t_comb;
		term(1, `GT_NAT_B, `IN_PAGE + 2);
		@(posedge clk);
		fuse.cell_cfg[8].reg_sel <= 1'b0;
		core_u.wr(8'he0, 8'h04);
		settle(3);
		chk(8'(gb[0]), 8'h01);
		@(posedge clk);
		fuse.cell_cfg[8].polarity <= 1'b1;
		settle(3);
		chk(8'(gb[0]), 8'h00);
	endtask

	task automatic t_pin;
		term(1, 3, `IN_PAGE + 4);
		@(posedge clk);
		fuse.cell_cfg[1].clk_pin <= 1'b1;
		core_u.wr(8'he0, 8'h10);
		settle(3);
		chk(8'(ga[1]), 8'h00);
		@(posedge clk);
		cell_clock_pin <= 1'b1;
		settle(6);
		chk(8'(ga[1]), 8'h01);
		@(posedge clk);
		cell_clock_pin <= 1'b0;
	endtask

	task automatic t_inputs;
		@(posedge clk);
		port_in <= 20'h53ca1;
		settle(3);
		core_u.rd(8'h10, d);
		chk(d, 8'ha1);
		core_u.rd(8'h11, d);
		chk(d, 8'h3c);
		core_u.rd(8'h12, d);
		chk(d, 8'h05);
	endtask

	task automatic t_toggle;
		term(1, 6, `IN_PAGE + 5);
		term(1, `GT_CLK + 2, `IN_PAGE + 6);
		@(posedge clk);
		fuse.cell_cfg[2].ff_type <= FF_T;
		core_u.wr(8'he0, 8'h20);
		settle(2);
		chk(8'(ga[2]), 8'h01);
		core_u.wr(8'he0, 8'h60);
		settle(2);
		chk(8'(ga[2]), 8'h00);
		core_u.wr(8'he0, 8'h20);
		settle(2);
		chk(8'(ga[2]), 8'h00);
		core_u.wr(8'he0, 8'h60);
		settle(2);
		chk(8'(ga[2]), 8'h01);
		term(1, `GT_PRESET + 10, `IN_PAGE + 7);
		core_u.wr(8'he0, 8'h80);
		settle(2);
		chk(8'(gb[2]), 8'h01);
		term(1, `GT_PRESET + 10, -1);
	endtask

	task automatic t_ecs;
		term(1, `GT_ECS, 0);
		core_u.bus('{fetch: 1'b0, read: 1'b0, write: 1'b0, latch: 1'b0, addr: 16'h0001});
		settle(3);
		chk(8'(ecs), 8'h01);
	endtask

	task automatic t_standby;
		@(posedge clk);
		fast_decode <= 1'b0;
		settle(6);
		chk(8'(standby), 8'h01);
		core_u.bus('{fetch: 1'b0, read: 1'b0, write: 1'b0, latch: 1'b0, addr: 16'h0002});
		settle(1);
		chk(8'(standby), 8'h00);
		@(posedge clk);
		fast_decode <= 1'b1;
		settle(6);
		chk(8'(standby), 8'h00);
	endtask

	// ============================================================
	// Main sequence
	initial begin
		n_fail = 0;
		checks = 0;
		resetn = 1'b0;
		ce = 1'b1;
		fast_decode = 1'b1;
		strobe_block = 5'h00;
		port_in = 20'h00000;
		cell_clock_pin = 1'b0;
		fuse = '0;
		for (int i = 0; i < `DEC_TERMS; i++) begin
			fuse.dec_true[i][`IN_READY] = 1'b1;
			fuse.dec_comp[i][`IN_READY] = 1'b1;
		end
		for (int i = 0; i < `GEN_TERMS; i++) begin
			fuse.gen_true[i][`IN_READY] = 1'b1;
			fuse.gen_comp[i][`IN_READY] = 1'b1;
		end
		for (int i = 0; i < `OUT_CELLS; i++)
			fuse.cell_cfg[i].reg_sel = 1'b1;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		settle(1);
		t_page();
		t_decode();
		t_block();
		t_cells();
		t_comb();
		t_pin();
		t_inputs();
		t_toggle();
		t_ecs();
		t_standby();
		end_sim();
	end

	initial begin
		#250000;
		n_fail++;
		end_sim();
	end
endmodule
